// ===== logic/aten_pkg.sv
// Constants, field positions and types shared by the link enhancement block.
package aten_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ATEN_OFS_SET = 12'hA88;  // Set view.
    localparam logic [11:0] ATEN_OFS_CLR = 12'hA8C;  // Clear view.
    localparam logic [11:0] ATEN_OFS_CFG = 12'h0F4;  // Configuration copy.

    // ------------------------------------------------------------------
    // Field positions and reset value
    // ------------------------------------------------------------------
    localparam int ATEN_BIT_REORDER_DIS = 15;
    localparam int ATEN_THRESH_LSB      = 12;
    localparam int ATEN_BIT_MPEG        = 10;
    localparam int ATEN_BIT_DV          = 8;
    localparam int ATEN_BIT_PRIO        = 7;
    localparam int ATEN_BIT_ACCEL       = 1;
    localparam logic [31:0] ATEN_WR_MASK = 32'h0000B582;
    localparam logic [31:0] ATEN_RESET   = 32'h00001000;

    // ------------------------------------------------------------------
    // Stream format codes and transmit thresholds
    // ------------------------------------------------------------------
    localparam logic [5:0]  ATEN_FMT_MPEG = 6'h20;
    localparam logic [5:0]  ATEN_FMT_DV   = 6'h00;
    localparam logic [11:0] ATEN_TH_2K    = 12'h800;
    localparam logic [11:0] ATEN_TH_1K7   = 12'h6C0;
    localparam logic [11:0] ATEN_TH_1K    = 12'h400;
    localparam logic [11:0] ATEN_TH_512   = 12'h200;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int ATEN_WORD_W     = 32;
    localparam int ATEN_FIFO_DEPTH = 16;
    localparam int ATEN_BUF_DEPTH  = 512;

    typedef enum logic [1:0] {
        ATEN_THS_SAF = 2'b00,
        ATEN_THS_1K7 = 2'b01,
        ATEN_THS_1K  = 2'b10,
        ATEN_THS_512 = 2'b11
    } aten_thresh_t;

    typedef enum logic [1:0] {
        ATEN_ST_IDLE  = 2'b00,
        ATEN_ST_SEND  = 2'b01,
        ATEN_ST_FLUSH = 2'b10,
        ATEN_ST_WACK  = 2'b11
    } aten_tx_state_t;

endpackage

// ===== logic/aten_fifo.sv
// Parameterised valid/ready FIFO that stages words ahead of the transmit buffer.
`timescale 1ns/10ps
module aten_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // Storage has no reset; only pointers and count need a defined value.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointer and occupancy update.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // aten_fifo

// ===== logic/aten_start_gate.sv
// Start-of-transmit decision from threshold selection and buffer state.
`timescale 1ns/10ps
module aten_start_gate
    import aten_pkg::*;
(
    input  wire logic        saf_mode,
    input  wire logic [1:0]  thresh_sel,
    input  wire logic [9:0]  fill_words,
    input  wire logic        eop_in_buf,
    input  wire logic        buf_full,
    output logic             start_ok,
    output logic [11:0]      thresh_bytes
);
    logic [11:0] fill_bytes;

    // Forced store-and-forward overrides the programmed selection.
    always_comb begin
        if (saf_mode) begin
            thresh_bytes = ATEN_TH_2K;
        end else begin
            unique case (aten_thresh_t'(thresh_sel))
                ATEN_THS_SAF: thresh_bytes = ATEN_TH_2K;
                ATEN_THS_1K7: thresh_bytes = ATEN_TH_1K7;
                ATEN_THS_1K:  thresh_bytes = ATEN_TH_1K;
                ATEN_THS_512: thresh_bytes = ATEN_TH_512;
            endcase
        end
    end

    assign fill_bytes = {fill_words, 2'b00};

    // A whole packet in the buffer always starts; a full buffer starts so it cannot lock up.
    always_comb begin
        if (saf_mode || thresh_bytes == ATEN_TH_2K) begin
            start_ok = eop_in_buf || buf_full;
        end else begin
            start_ok = eop_in_buf || (fill_bytes >= thresh_bytes);
        end
    end
endmodule // aten_start_gate

// ===== logic/aten_link_enh.sv
// Link enhancement control register and asynchronous transmit threshold path.
//
// What this block does
// - Bits 31-16 and 5-2 read zero.
// - Bits 11, 9, 0 read zero, unwritable.
// - Bit 15 forces strictly in-order transmit.
// - Bits 13-12 pick 2K/1.7K/1K/512 threshold.
// - Programmed threshold holds until first underrun.
// - Retried packets use 2K store-and-forward.
// - Start at threshold or on complete packet.
// - Underrun flags error, then store-and-forward.
// - 2K threshold waits for end-of-packet token or a full buffer.
// - Zero retries register forces store-and-forward.
// - Bit 10 enables stamps for format 20h.
// - Bit 8 enables stamps for format 00h.
// - Bit 7 enables priority arbitration responses.
// - Bit 1 advertises acceleration to PHY.
// - Bit 6 unassigned; loaded bit drives permit.
// - Set view and clear view alias config.
`timescale 1ns/10ps
module aten_link_enh
    import aten_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_rdata_valid,
    input  wire logic        ee_permit_load,
    input  wire logic        ee_permit_value,
    output logic             phy_program_permit,
    input  wire logic        retries_zero,
    input  wire logic        tx_retry,
    input  wire logic        src_valid,
    output logic             src_ready,
    input  wire logic [31:0] src_data,
    input  wire logic        src_eop,
    output logic             link_valid,
    input  wire logic        link_ready,
    output logic [31:0]      link_data,
    output logic             link_eop,
    input  wire logic        link_ack,
    output logic             tx_underrun,
    output logic             saf_active,
    output logic             tx_reorder_disable,
    input  wire logic [5:0]  stamp_fmt,
    output logic             stamp_enhance,
    output logic             transport_stamp_enhance_en,
    output logic             video_cip_stamp_enhance_en,
    output logic             priority_arb_en,
    output logic             phy_accel_notify
);
    localparam int BAW = $clog2(ATEN_BUF_DEPTH);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0]          ctrl_reg;
    logic [31:0]          rdata_reg;
    logic                 rvalid_reg;
    logic                 permit_reg;
    logic                 stamp_reg;
    logic                 saf_sticky_reg;
    logic                 underrun_reg;
    aten_tx_state_t       state_reg;
    logic                 lvalid_reg;
    logic [31:0]          ldata_reg;
    logic                 leop_reg;
    logic [32:0]          buf_mem [ATEN_BUF_DEPTH];
    logic [BAW-1:0]       bwr_ptr_reg;
    logic [BAW-1:0]       brd_ptr_reg;
    logic [9:0]           fill_reg;
    logic [9:0]           eop_cnt_reg;
    logic                 fifo_out_valid;
    logic                 fifo_out_ready;
    logic [32:0]          fifo_out_data;
    logic                 buf_full;
    logic                 buf_empty;
    logic                 buf_wr;
    logic                 buf_rd;
    logic [32:0]          buf_head;
    logic                 saf_mode;
    logic                 start_ok;
    logic [11:0]          thresh_bytes;
    logic                 underrun_now;
    logic                 hit_set;
    logic                 hit_clr;
    logic                 hit_cfg;

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    assign hit_set = (reg_addr == ATEN_OFS_SET);
    assign hit_clr = (reg_addr == ATEN_OFS_CLR);
    assign hit_cfg = (reg_addr == ATEN_OFS_CFG);

    // The mask keeps reserved bits at zero whichever view is written.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= ATEN_RESET;
        end else if (reg_wr && hit_set) begin
            ctrl_reg <= ctrl_reg | (reg_wdata & ATEN_WR_MASK);
        end else if (reg_wr && hit_clr) begin
            ctrl_reg <= ctrl_reg & ~(reg_wdata & ATEN_WR_MASK);
        end else if (reg_wr && hit_cfg) begin
            ctrl_reg <= reg_wdata & ATEN_WR_MASK;
        end
    end

    // Read data is answered one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd && (hit_set || hit_clr || hit_cfg)) begin
                rdata_reg <= ctrl_reg & ATEN_WR_MASK;
            end else if (reg_rd) begin
                rdata_reg <= '0;
            end
        end
    end

    assign reg_rdata       = rdata_reg;
    assign reg_rdata_valid = rvalid_reg;

    // The enhancement bit loaded at position 6 is not kept here; it drives the permit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            permit_reg <= 1'b0;
        end else if (ee_permit_load) begin
            permit_reg <= ee_permit_value;
        end
    end

    assign phy_program_permit = permit_reg;

    // ------------------------------------------------------------------
    // Enhancement enables
    // ------------------------------------------------------------------
    assign tx_reorder_disable         = ctrl_reg[ATEN_BIT_REORDER_DIS];
    assign transport_stamp_enhance_en = ctrl_reg[ATEN_BIT_MPEG];
    assign video_cip_stamp_enhance_en = ctrl_reg[ATEN_BIT_DV];
    assign priority_arb_en            = ctrl_reg[ATEN_BIT_PRIO];
    assign phy_accel_notify           = ctrl_reg[ATEN_BIT_ACCEL];

    // Stamp enable is registered so it changes cleanly with the format input.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stamp_reg <= 1'b0;
        end else begin
            stamp_reg <= (ctrl_reg[ATEN_BIT_MPEG] && stamp_fmt == ATEN_FMT_MPEG)
                      || (ctrl_reg[ATEN_BIT_DV] && stamp_fmt == ATEN_FMT_DV);
        end
    end

    assign stamp_enhance = stamp_reg;

    // ------------------------------------------------------------------
    // Staging FIFO and transmit buffer
    // ------------------------------------------------------------------
    aten_fifo #(
        .WIDTH (33),
        .DEPTH (ATEN_FIFO_DEPTH)
    ) u_stage (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (src_valid),
        .in_ready  (src_ready),
        .in_data   ({src_eop, src_data}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // A full buffer stalls the FIFO, which in turn stalls the source.
    assign buf_full       = (fill_reg == 10'(ATEN_BUF_DEPTH));
    assign buf_empty      = (fill_reg == '0);
    assign fifo_out_ready = !buf_full;
    assign buf_wr         = fifo_out_valid && !buf_full;
    assign buf_head       = buf_mem[brd_ptr_reg];

    always_ff @(posedge ref_clk) begin
        if (buf_wr) begin
            buf_mem[bwr_ptr_reg] <= fifo_out_data;
        end
    end

    // Fill and end-of-packet counts tell the gate how much is checked in.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bwr_ptr_reg <= '0;
            brd_ptr_reg <= '0;
            fill_reg    <= '0;
            eop_cnt_reg <= '0;
        end else begin
            bwr_ptr_reg <= bwr_ptr_reg + BAW'(buf_wr);
            brd_ptr_reg <= brd_ptr_reg + BAW'(buf_rd);
            fill_reg    <= fill_reg + 10'(buf_wr) - 10'(buf_rd);
            eop_cnt_reg <= eop_cnt_reg + 10'(buf_wr && fifo_out_data[32])
                         - 10'(buf_rd && buf_head[32]);
        end
    end

    // ------------------------------------------------------------------
    // Start decision
    // ------------------------------------------------------------------
    // Retries, a zero retry limit and a past underrun all force store-and-forward.
    assign saf_mode   = saf_sticky_reg || tx_retry || retries_zero;
    assign saf_active = saf_mode;

    aten_start_gate u_gate (
        .saf_mode     (saf_mode),
        .thresh_sel   (ctrl_reg[ATEN_THRESH_LSB+1:ATEN_THRESH_LSB]),
        .fill_words   (fill_reg),
        .eop_in_buf   (eop_cnt_reg != '0),
        .buf_full     (buf_full),
        .start_ok     (start_ok),
        .thresh_bytes (thresh_bytes)
    );

    // ------------------------------------------------------------------
    // Transmit sequencing
    // ------------------------------------------------------------------
    // The buffer drains when a word is handed out or while a broken packet is dropped.
    always_comb begin
        buf_rd = 1'b0;
        unique case (state_reg)
            ATEN_ST_IDLE:  buf_rd = start_ok && !buf_empty;
            ATEN_ST_SEND:  buf_rd = link_ready && !leop_reg && !buf_empty;
            ATEN_ST_FLUSH: buf_rd = !buf_empty;
            ATEN_ST_WACK:  buf_rd = 1'b0;
        endcase
    end

    // Underrun: the link wants the next word of an unfinished packet and none is there.
    assign underrun_now = (state_reg == ATEN_ST_SEND) && link_ready && !leop_reg && buf_empty;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg  <= ATEN_ST_IDLE;
            lvalid_reg <= 1'b0;
            ldata_reg  <= '0;
            leop_reg   <= 1'b0;
        end else begin
            unique case (state_reg)
                ATEN_ST_IDLE: begin
                    if (buf_rd) begin
                        lvalid_reg <= 1'b1;
                        ldata_reg  <= buf_head[31:0];
                        leop_reg   <= buf_head[32];
                        state_reg  <= ATEN_ST_SEND;
                    end
                end
                ATEN_ST_SEND: begin
                    if (link_ready && leop_reg) begin
                        lvalid_reg <= 1'b0;
                        leop_reg   <= 1'b0;
                        // In-order mode holds the next packet until the link acknowledges.
                        state_reg  <= tx_reorder_disable ? ATEN_ST_WACK : ATEN_ST_IDLE;
                    end else if (buf_rd) begin
                        ldata_reg <= buf_head[31:0];
                        leop_reg  <= buf_head[32];
                    end else if (underrun_now) begin
                        lvalid_reg <= 1'b0;
                        state_reg  <= ATEN_ST_FLUSH;
                    end
                end
                ATEN_ST_FLUSH: begin
                    // The remains of the broken packet are discarded up to its end token.
                    if (buf_rd && buf_head[32]) begin
                        state_reg <= ATEN_ST_IDLE;
                    end
                end
                ATEN_ST_WACK: begin
                    if (link_ack) begin
                        state_reg <= ATEN_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // The first underrun ends use of the programmed threshold until reset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            saf_sticky_reg <= 1'b0;
            underrun_reg   <= 1'b0;
        end else begin
            underrun_reg <= underrun_now;
            if (underrun_now) begin
                saf_sticky_reg <= 1'b1;
            end
        end
    end

    assign tx_underrun = underrun_reg;
    assign link_valid  = lvalid_reg;
    assign link_data   = ldata_reg;
    assign link_eop    = leop_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_rsvd_read_zero: assert property (
        rvalid_reg |-> (reg_rdata[31:16] == 16'h0000 && reg_rdata[5:2] == 4'h0)
    ) else $error("Reserved upper or middle bits read nonzero.");

    a_rsvd_bits_fixed: assert property (
        !ctrl_reg[11] && !ctrl_reg[9] && !ctrl_reg[0] && !ctrl_reg[6]
    ) else $error("Reserved single bits became nonzero.");

    a_set_view_sets: assert property (
        (reg_wr && hit_set) |=>
            ((ctrl_reg & ($past(reg_wdata) & ATEN_WR_MASK)) == ($past(reg_wdata) & ATEN_WR_MASK))
            && ((ctrl_reg & ~$past(reg_wdata)) == ($past(ctrl_reg) & ~$past(reg_wdata)))
    ) else $error("Set view did not set exactly the written ones.");

    a_clear_view_clears: assert property (
        (reg_wr && hit_clr) |=>
            ((ctrl_reg & $past(reg_wdata) & ATEN_WR_MASK) == 32'h00000000)
            && ((ctrl_reg & ~$past(reg_wdata)) == ($past(ctrl_reg) & ~$past(reg_wdata)))
    ) else $error("Clear view did not clear exactly the written ones.");

    a_inorder_wait: assert property (
        (state_reg == ATEN_ST_SEND && link_ready && leop_reg && tx_reorder_disable)
            |=> (state_reg == ATEN_ST_WACK) [*1] ##0 !lvalid_reg
    ) else $error("In-order mode did not wait for the link acknowledge.");

    a_thresh_decode: assert property (
        !saf_mode |-> (thresh_bytes == ((ctrl_reg[13:12] == 2'b00) ? ATEN_TH_2K :
                                        (ctrl_reg[13:12] == 2'b01) ? ATEN_TH_1K7 :
                                        (ctrl_reg[13:12] == 2'b10) ? ATEN_TH_1K : ATEN_TH_512))
    ) else $error("Threshold field decoded to the wrong level.");

    a_saf_holds: assert property (
        (state_reg == ATEN_ST_IDLE && (saf_mode || ctrl_reg[13:12] == 2'b00)
            && eop_cnt_reg == '0 && !buf_full) |=> !lvalid_reg
    ) else $error("Store-and-forward sent before a whole packet was in.");

    a_forced_saf: assert property (
        (retries_zero || tx_retry) |-> (thresh_bytes == ATEN_TH_2K && saf_mode)
    ) else $error("Zero retries or a retry did not force store-and-forward.");

    a_thresh_start: assert property (
        (state_reg == ATEN_ST_IDLE && !buf_empty
            && ({fill_reg, 2'b00} >= thresh_bytes || eop_cnt_reg != '0))
            |=> (lvalid_reg && state_reg == ATEN_ST_SEND)
    ) else $error("Transmit did not start at the threshold.");

    a_underrun_saf: assert property (
        underrun_now |=> (tx_underrun && saf_active && !link_valid) ##1 !tx_underrun
    ) else $error("Underrun did not flag once and switch to store-and-forward.");

    a_saf_sticky: assert property (
        saf_sticky_reg |=> saf_sticky_reg
    ) else $error("Store-and-forward fallback was dropped before reset.");

    a_stamp_select: assert property (
        ##1 (stamp_enhance == (($past(ctrl_reg[ATEN_BIT_MPEG]) && $past(stamp_fmt) == 6'h20)
                            || ($past(ctrl_reg[ATEN_BIT_DV]) && $past(stamp_fmt) == 6'h00)))
    ) else $error("Stamp enhancement does not follow format and enables.");

endmodule // aten_link_enh

// ===== tb/aten_link_sink.sv
// Link-side receiver model that takes words and acknowledges packets.
`timescale 1ns/10ps
module aten_link_sink (
    input  wire logic ref_clk,
    input  wire logic stall,
    input  wire logic link_valid,
    input  wire logic link_eop,
    output logic      link_ready,
    output logic      link_ack,
    output int        n_words
);
    logic eop_seen;
    initial begin
        {link_ready, link_ack, eop_seen} = 3'h4;
        n_words = 0;
    end
    // Count words taken; a finished packet is acknowledged half a cycle later.
    always @(posedge ref_clk) begin
        if (link_valid && link_ready) begin
            n_words++;
        end
        eop_seen = link_valid & link_ready & link_eop;
    end
    // Ready and acknowledge move on the falling edge so the design never races them.
    always @(negedge ref_clk) begin
        link_ack <= eop_seen;
        link_ready <= ~stall;
    end
endmodule // aten_link_sink

// ===== tb/aten_link_enh_test.sv
// Self-checking bench for the link enhancement register and transmit path.
`timescale 1ns/10ps
module aten_link_enh_test
    import aten_pkg::*;
;
    logic        ref_clk, rst, reg_wr, reg_rd, rd_valid, retries_zero, tx_retry, stall;
    logic        src_valid, src_eop, src_ready, link_valid, link_ready, link_eop, link_ack;
    logic        tx_underrun, saf_active, stamp_enh, permit, reo, mpeg, dv, prio, accel;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, src_data, link_data;
    logic [5:0]  stamp_fmt;
    int          n_mismatch, checks_done, n_words, n0;

    aten_link_enh aten_link_enh_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(rd_valid), .ee_permit_load(1'b1), .ee_permit_value(1'b1),
        .phy_program_permit(permit), .retries_zero(retries_zero), .tx_retry(tx_retry),
        .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .src_eop(src_eop),
        .link_valid(link_valid), .link_ready(link_ready), .link_data(link_data),
        .link_eop(link_eop), .link_ack(link_ack), .tx_underrun(tx_underrun),
        .saf_active(saf_active), .tx_reorder_disable(reo), .stamp_fmt(stamp_fmt),
        .stamp_enhance(stamp_enh), .transport_stamp_enhance_en(mpeg),
        .video_cip_stamp_enhance_en(dv), .priority_arb_en(prio), .phy_accel_notify(accel));
    aten_link_sink aten_link_sink_inst (.ref_clk(ref_clk), .stall(stall),
        .link_valid(link_valid), .link_eop(link_eop), .link_ready(link_ready),
        .link_ack(link_ack), .n_words(n_words));

    // ------------------------------------------------------------------
    // Clock, comparison and bus tasks
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    // Read data lands on the edge that takes the strobe, half a cycle before the check.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("rdata_valid", 32'h1, {31'h0, rd_valid});
        chk("reg_rdata", exp, reg_rdata);
    endtask
    // A word is held on the bus until ready shows, so the next edge takes it.
    task automatic put(input int n, input logic e);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            {src_valid, src_data, src_eop} = {1'b1, 32'(i), e && i == n - 1};
            while (src_ready !== 1'b1) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        src_valid = 1'b0;
    endtask
    task automatic fmt_chk(input logic [5:0] f, input logic exp);
        @(negedge ref_clk);
        stamp_fmt = f;
        repeat (2) @(negedge ref_clk);
        chk("stamp_enhance", {31'h0, exp}, {31'h0, stamp_enh});
    endtask
    task automatic settle(input int tgt);
        for (int k = 0; k < 600 && n_words < tgt; k++) @(negedge ref_clk);
        chk("link words", 32'(tgt), 32'(n_words));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(ATEN_OFS_SET, ATEN_RESET);
        wr(ATEN_OFS_SET, 32'hFFFFFFFF);
        rd(ATEN_OFS_CLR, ATEN_WR_MASK);
        chk("enables", 32'h1F, {27'h0, reo, mpeg, dv, prio, accel});
        wr(ATEN_OFS_CLR, 32'h00008000);
        rd(ATEN_OFS_CFG, 32'h00003582);
        wr(ATEN_OFS_CLR, 32'hFFFFFFFF);
        rd(ATEN_OFS_SET, 32'h00000000);
        rd(12'h100, 32'h00000000);
        chk("permit", 32'h1, {31'h0, permit});
    endtask
    task automatic t_stamp;
        wr(ATEN_OFS_SET, 32'h00000400);
        fmt_chk(6'h20, 1'b1);
        fmt_chk(6'h00, 1'b0);
        wr(ATEN_OFS_CLR, 32'h00000400);
        wr(ATEN_OFS_SET, 32'h00000100);
        fmt_chk(6'h00, 1'b1);
        fmt_chk(6'h20, 1'b0);
    endtask
    // Threshold field is 00 here: nothing leaves before the packet end.
    task automatic t_saf;
        put(4, 1'b0);
        repeat (10) @(negedge ref_clk);
        chk("link_valid held", 32'h0, {31'h0, link_valid});
        chk("saf idle", 32'h0, {31'h0, saf_active});
        {retries_zero, tx_retry} = 2'b10;
        #1 chk("saf retries", 32'h1, {31'h0, saf_active});
        {retries_zero, tx_retry} = 2'b01;
        #1 chk("saf retry", 32'h1, {31'h0, saf_active});
        tx_retry = 1'b0;
        put(1, 1'b1);
        settle(5);
    endtask
    // 512-byte start, the source stops short, the buffer runs dry.
    task automatic t_underrun;
        logic seen;
        seen = 1'b0;
        wr(ATEN_OFS_SET, 32'h0000B000);
        n0 = n_words;
        put(130, 1'b0);
        for (int k = 0; k < 300 && !seen; k++) begin
            @(negedge ref_clk);
            seen = tx_underrun;
        end
        chk("underrun", 32'h1, {31'h0, seen});
        chk("last data", 32'h81, link_data);
        chk("started", 32'h1, {31'h0, n_words - n0 >= 128});
        chk("saf sticky", 32'h1, {31'h0, saf_active});
        put(1, 1'b1);
        n0 = n_words;
        put(130, 1'b0);
        repeat (20) @(negedge ref_clk);
        chk("no start", 32'(n0), 32'(n_words));
        stall = 1'b1;
        put(1, 1'b1);
        repeat (20) @(negedge ref_clk);
        chk("stalled", 32'(n0), 32'(n_words));
        stall = 1'b0;
        settle(n0 + 131);
    endtask

    // ------------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------------
    task automatic conclude;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        {rst, reg_wr, reg_rd, src_valid, src_eop, retries_zero, tx_retry, stall} = 8'h80;
        {reg_addr, reg_wdata, src_data, stamp_fmt} = '0;
        {n_mismatch, checks_done} = '0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_regs;
        t_stamp;
        t_saf;
        t_underrun;
        conclude;
    end
    // The tests need several hundred cycles; this span of 40000 cycles is far beyond that.
    initial begin
        #400000;
        n_mismatch++;
        conclude;
    end
endmodule // aten_link_enh_test
